// *** rlp_board.sv ***
// board model: two push-buttons and the six transistor-driven led channels
`timescale 1ns/1ps
module rlp_board
   import rlp_pkg::*;
(
   input wire logic clk,
   input wire logic clr,
   input wire logic [1:0] press,
   input rlp_pkg::rlp_rgb_t led0,
   input rlp_pkg::rlp_rgb_t led1,
   output logic [1:0] btn_in,
   output logic [5:0][8:0] lit
);
   // released button reads low, pressed reads high, no bounce modelled
   assign btn_in = press;
   function automatic logic ch_of(input int i);
      logic [5:0] ch;
      ch = {led1, led0};
      return ch[i];
   endfunction
   // lit-cycle counters; a high pin lights the element through the inverter
   always_ff @(posedge clk) begin
      for (int i = 0; i < 6; i++) begin
         lit[i] <= clr ? 9'h000 : lit[i] + {8'h00, ch_of(i)};
      end
   end
endmodule

// *** rlp_defs.svh ***
// constants for the rgb led pwm and button block
`ifndef RLP_DEFS_SVH
`define RLP_DEFS_SVH
`define RLP_NUM_LEDS 2
`define RLP_NUM_CH 6
`define RLP_NUM_BTN 2
`define RLP_CNT_W 8
`define RLP_DUTY_W 8
`define RLP_ADDR_W 4
`define RLP_DUTY_MAX 8'h80
`define RLP_CNT_ZERO 8'h00
`define RLP_REG_DUTY_BASE 4'h0
`define RLP_REG_CTRL 4'h6
`define RLP_REG_BTN 4'h7
`define RLP_REG_STAT 4'h8
`define RLP_CTRL_RST 1'b0
`endif

// *** rlp_pkg.sv ***
// types for the rgb led pwm and button block
`include "rlp_defs.svh"
package rlp_pkg;
   typedef struct packed {
      logic [`RLP_ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } rlp_bus_req_t;
   typedef struct packed {
      logic red;
      logic green;
      logic blue;
   } rlp_rgb_t;
   typedef enum logic [1:0] {
      RLP_ST_IDLE = 2'b01,
      RLP_ST_RUN = 2'b10
   } rlp_state_t;
endpackage

// *** rlp_top.sv ***
// rgb led pwm generator with push-button readback
`timescale 1ns/1ps
`include "rlp_defs.svh"

// Functional notes
// - two buttons, two leds, six channels
// - drive output high to light element
// - red green blue channels independent per led
// - pwm output high at most half period
// - duty settable per channel 0 to 50%
module rlp_top
   import rlp_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input rlp_pkg::rlp_bus_req_t bus_req,
   output logic [31:0] rd_data,
   input wire logic [`RLP_NUM_BTN-1:0] btn_in,
   output rlp_pkg::rlp_rgb_t led0,
   output rlp_pkg::rlp_rgb_t led1
);
   import rlp_pkg::*;

   // clamp keeps every channel at or below half period
   function automatic logic [`RLP_DUTY_W-1:0] clamp_duty(input logic [31:0] v);
      clamp_duty = (v > 32'(`RLP_DUTY_MAX)) ? `RLP_DUTY_MAX : v[`RLP_DUTY_W-1:0];
   endfunction

   function automatic logic is_duty_addr(input logic [`RLP_ADDR_W-1:0] a, input int i);
      is_duty_addr = (a == `RLP_ADDR_W'(`RLP_REG_DUTY_BASE + i));
   endfunction

   logic [`RLP_DUTY_W-1:0] duty_q [`RLP_NUM_CH];
   logic [`RLP_DUTY_W-1:0] duty_d [`RLP_NUM_CH];
   logic en_q, en_d;
   logic [`RLP_CNT_W-1:0] cnt_q, cnt_d;
   rlp_state_t st_q, st_d;
   logic [`RLP_NUM_CH-1:0] pwm_q;
   wire logic [`RLP_NUM_CH-1:0] pwm_d; // one comparator drives each bit
   logic [`RLP_NUM_BTN-1:0] btn_q, btn_d;
   logic [31:0] rd_q, rd_d;

   // register writes and state machine next values
   always_comb begin
      for (int i = 0; i < `RLP_NUM_CH; i++) begin
         duty_d[i] = duty_q[i];
         if (bus_req.wr && is_duty_addr(bus_req.addr, i)) begin
            duty_d[i] = clamp_duty(bus_req.wdata);
         end
      end
      en_d = en_q;
      if (bus_req.wr && bus_req.addr == `RLP_REG_CTRL) begin
         en_d = bus_req.wdata[0];
      end
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         RLP_ST_IDLE: begin
            cnt_d = `RLP_CNT_ZERO;
            if (en_q) begin
               st_d = RLP_ST_RUN;
            end
         end
         RLP_ST_RUN: begin
            cnt_d = cnt_q + `RLP_CNT_W'(1); // free-running 256-cycle period
            if (!en_q) begin
               st_d = RLP_ST_IDLE;
            end
         end
         default: begin
            st_d = RLP_ST_IDLE;
         end
      endcase
      // buttons taken as synchronous, high means pressed
      btn_d = btn_in;
   end

   // per-channel comparators, one per colour element
   generate
      for (genvar g = 0; g < `RLP_NUM_CH; g++) begin : g_ch
         // lit only when counter below duty, so duty 0 stays dark
         assign pwm_d[g] = (st_q == RLP_ST_RUN) && (cnt_q < duty_q[g]);
      end
   endgenerate

   // read mux, data presented one cycle after the strobe
   always_comb begin
      rd_d = 32'h0;
      if (bus_req.rd) begin
         if (bus_req.addr < `RLP_ADDR_W'(`RLP_NUM_CH)) begin
            rd_d = {24'h0, duty_q[bus_req.addr[2:0]]};
         end else if (bus_req.addr == `RLP_REG_CTRL) begin
            rd_d = {31'h0, en_q};
         end else if (bus_req.addr == `RLP_REG_BTN) begin
            rd_d = {30'h0, btn_q};
         end else if (bus_req.addr == `RLP_REG_STAT) begin
            rd_d = {24'h0, cnt_q};
         end
      end
   end

   // state registers, frozen while the clock enable is low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < `RLP_NUM_CH; i++) begin
            duty_q[i] <= `RLP_CNT_ZERO;
         end
         en_q <= `RLP_CTRL_RST;
         cnt_q <= `RLP_CNT_ZERO;
         st_q <= RLP_ST_IDLE;
         pwm_q <= '0;
         btn_q <= '0;
         rd_q <= 32'h0;
      end else if (clk_en) begin
         duty_q <= duty_d;
         en_q <= en_d;
         cnt_q <= cnt_d;
         st_q <= st_d;
         pwm_q <= pwm_d;
         btn_q <= btn_d;
         rd_q <= rd_d;
      end
   end

   // high level lights the element through the inverting transistor
   assign led0 = rlp_rgb_t'(pwm_q[2:0]);
   assign led1 = rlp_rgb_t'(pwm_q[5:3]);
   assign rd_data = rd_q;

   // channel watched by the period checks; the clamp path is the risky one
   localparam int MON_CH = 4;

   // count high cycles of the watched channel within a period
   logic [`RLP_CNT_W:0] hi_cnt_q, hi_cnt_d;
   always_comb begin
      hi_cnt_d = hi_cnt_q;
      if (cnt_q == `RLP_CNT_ZERO) begin
         hi_cnt_d = '0;
      end else if (pwm_q[MON_CH]) begin
         hi_cnt_d = hi_cnt_q + 9'h1;
      end
   end

   // helper register only, frozen with the rest of the state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hi_cnt_q <= '0;
      end else if (clk_en) begin
         hi_cnt_q <= hi_cnt_d;
      end
   end

   property p_half_max;
      @(posedge clk) disable iff (reset) hi_cnt_q <= {1'b0, `RLP_DUTY_MAX};
   endproperty
   a_half_max: assert property (p_half_max) else $error("channel high over half period");

   property p_zero_dark;
      @(posedge clk) disable iff (reset) (clk_en && duty_q[0] == `RLP_CNT_ZERO) |=> !pwm_q[0];
   endproperty
   a_zero_dark: assert property (p_zero_dark) else $error("zero duty channel lit");

   property p_idle_dark;
      @(posedge clk) disable iff (reset) (clk_en && st_q == RLP_ST_IDLE) |=> (pwm_q == '0);
   endproperty
   a_idle_dark: assert property (p_idle_dark) else $error("led lit while disabled");

   property p_duty_cap;
      @(posedge clk) disable iff (reset) duty_q[MON_CH] <= `RLP_DUTY_MAX;
   endproperty
   a_duty_cap: assert property (p_duty_cap) else $error("duty above half");

   property p_btn_read;
      @(posedge clk) disable iff (reset)
         (clk_en && bus_req.rd && bus_req.addr == `RLP_REG_BTN) |=> (rd_data[1:0] == $past(btn_q));
   endproperty
   a_btn_read: assert property (p_btn_read) else $error("button readback wrong");

   property p_led_map;
      @(posedge clk) disable iff (reset) (led1.blue == pwm_q[3]) && (led0.red == pwm_q[2]);
   endproperty
   a_led_map: assert property (p_led_map) else $error("led channel map wrong");

   property p_lit_cause;
      @(posedge clk) disable iff (reset) $rose(pwm_q[3]) |-> $past(st_q == RLP_ST_RUN);
   endproperty
   a_lit_cause: assert property (p_lit_cause) else $error("lit without run");

   property p_count_step;
      @(posedge clk) disable iff (reset)
         (clk_en && st_q == RLP_ST_RUN && en_q) |=> (cnt_q == $past(cnt_q) + 8'h1);
   endproperty
   a_count_step: assert property (p_count_step) else $error("period counter stalled");

   // reset walk: dark at the release edge and at the one after it
   sequence s_all_dark;
      (pwm_q == '0) && (rd_data == 32'h0);
   endsequence
   property p_reset_dark;
      @(posedge clk) $fell(reset) |-> s_all_dark ##1 s_all_dark;
   endproperty
   a_reset_dark: assert property (p_reset_dark) else $error("led lit right after reset");

   // enable walk: control write taken, one more enabled edge, then running
   sequence s_ctrl_on;
      clk_en && bus_req.wr && (bus_req.addr == `RLP_REG_CTRL) && bus_req.wdata[0];
   endsequence
   sequence s_ctrl_taken;
      s_ctrl_on ##1 clk_en;
   endsequence
   property p_enable_walk;
      @(posedge clk) disable iff (reset) s_ctrl_taken |=> (st_q == RLP_ST_RUN);
   endproperty
   a_enable_walk: assert property (p_enable_walk) else $error("enable did not start the period");

   // an over-range write lands as exactly half a period
   property p_clamp_write;
      @(posedge clk) disable iff (reset)
         (clk_en && bus_req.wr && is_duty_addr(bus_req.addr, MON_CH)
            && (bus_req.wdata > 32'(`RLP_DUTY_MAX)))
            |=> (duty_q[MON_CH] == `RLP_DUTY_MAX);
   endproperty
   a_clamp_write: assert property (p_clamp_write) else $error("over-range duty not clamped");

   // past the duty point the channel stays dark for the rest of the period
   property p_dark_above;
      @(posedge clk) disable iff (reset)
         (clk_en && st_q == RLP_ST_RUN && cnt_q >= duty_q[MON_CH]) |=> !pwm_q[MON_CH];
   endproperty
   a_dark_above: assert property (p_dark_above) else $error("channel lit past its duty");
endmodule

// *** rlp_top_tb.sv ***
// self-checking bench for the rgb led pwm and button block
`timescale 1ns/1ps
`include "rlp_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module rlp_top_tb;
   import rlp_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic clr = 1'b0;
   logic [1:0] press = 2'h0;
   logic [1:0] btn_in;
   rlp_bus_req_t bus_req = '0;
   logic [31:0] rd_data;
   logic [31:0] q;
   rlp_rgb_t led0;
   rlp_rgb_t led1;
   logic [5:0][8:0] lit;
   logic [7:0] dv [6] = '{8'h00, 8'h01, 8'h40, 8'h80, 8'hff, 8'h7f};
   int mismatches = 0;
   int check_count = 0;
   always #2 clk = ~clk;
   rlp_top rlp_top_i(.clk(clk), .reset(reset), .clk_en(clk_en), .bus_req(bus_req), .rd_data(rd_data),
      .btn_in(btn_in), .led0(led0), .led1(led1));
   rlp_board rlp_board_i(.clk(clk), .clr(clr), .press(press), .led0(led0), .led1(led1), .btn_in(btn_in), .lit(lit));
   // one-cycle write strobe
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req <= {a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task rd(input logic [3:0] a);
      @(posedge clk);
      bus_req <= {a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      @(negedge clk);
      q = rd_data;
   endtask
   // count lit cycles over exactly one 256-cycle period
   task window;
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (256) @(posedge clk);
      @(negedge clk);
   endtask
   task t_reset;
      `CHK({led1, led0}, 6'h00)
      rd(`RLP_REG_CTRL);
      `CHK(q, 32'h0)
      $display("t_reset done");
   endtask
   task t_buttons;
      for (int p = 0; p < 4; p++) begin
         @(posedge clk);
         press <= p[1:0];
         rd(`RLP_REG_BTN);
         `CHK(q, {30'h0, p[1:0]})
      end
      rd(4'hf);
      `CHK(q, 32'h0)
      $display("t_buttons done");
   endtask
   // boundary duties, an over-range clamp, all six channels at once
   task t_duty;
      for (int i = 0; i < 6; i++) wr(4'(i), {24'h0, dv[i]});
      wr(`RLP_REG_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      window();
      for (int i = 0; i < 6; i++) `CHK(lit[i], {1'b0, (dv[i] > 8'h80) ? 8'h80 : dv[i]})
      wr(`RLP_REG_CTRL, 32'h0);
      repeat (4) @(posedge clk);
      window();
      `CHK(lit, 54'h0)
      $display("t_duty done");
   endtask
   // clock enable low freezes the period counter; read data stand one cycle
   task t_freeze;
      logic [7:0] c1;
      wr(`RLP_REG_CTRL, 32'h1);
      rd(`RLP_REG_CTRL);
      `CHK(q, 32'h1)
      @(negedge clk);
      `CHK(rd_data, 32'h0)
      rd(`RLP_REG_STAT);
      c1 = q[7:0];
      @(posedge clk);
      clk_en <= 1'b0;
      repeat (10) @(posedge clk);
      clk_en <= 1'b1;
      rd(`RLP_REG_STAT);
      `CHK(q, {24'h0, 8'(c1 + 8'h3)})
      $display("t_freeze done");
   endtask
   // reset in mid-run darkens every channel and clears duty and enable
   task t_rerun;
      wr(`RLP_REG_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      `CHK({led1, led0}, 6'h00)
      @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      `CHK({led1, led0}, 6'h00)
      rd(4'h3);
      `CHK(q, 32'h0)
      rd(`RLP_REG_CTRL);
      `CHK(q, 32'h0)
      $display("t_rerun done");
   endtask
   task end_of_test;
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      t_reset();
      t_buttons();
      t_duty();
      t_freeze();
      t_rerun();
      end_of_test();
   end
   // run needs about 610 cycles
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      end_of_test();
   end
endmodule
